/* logic/utd_pkg.sv */
package utd_pkg;
    // Clock and microframe timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int UFRAME_NS     = 125000;
    localparam int UFRAME_CYCLES = (UFRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W         = 11;

    // Descriptor memory geometry
    localparam int SLOT_W  = 5;
    localparam int SLOTS   = 32;
    localparam int WORD_W  = 3;
    localparam int RAM_AW  = SLOT_W + WORD_W;
    localparam logic [WORD_W-1:0] DW0 = 3'h0;
    localparam logic [WORD_W-1:0] DW1 = 3'h1;
    localparam logic [WORD_W-1:0] DW2 = 3'h2;
    localparam logic [WORD_W-1:0] DW3 = 3'h3;
    localparam logic [WORD_W-1:0] DW4 = 3'h4;

    // Word 0 fields
    localparam int ACT_BIT  = 0;
    localparam int BTM_LSB  = 3;
    localparam int BTM_MSB  = 17;
    localparam int MPS_LSB  = 18;
    localparam int MPS_MSB  = 28;
    localparam int MULT_LSB = 29;
    localparam int MULT_MSB = 30;
    localparam int EP0_BIT  = 31;
    // Word 1 fields
    localparam int EPH_LSB  = 0;
    localparam int EPH_MSB  = 2;
    localparam int FADR_LSB = 3;
    localparam int FADR_MSB = 9;
    localparam int TOK_LSB  = 10;
    localparam int TOK_MSB  = 11;
    localparam int KIND_LSB = 12;
    localparam int KIND_MSB = 13;
    localparam int SPLIT_BIT = 14;
    localparam int SE_LSB   = 16;
    localparam int SE_MSB   = 17;
    localparam int PORT_LSB = 18;
    localparam int PORT_MSB = 24;
    localparam int HUB_LSB  = 25;
    localparam int HUB_MSB  = 31;
    // Word 2 fields
    localparam int POLL_LSB  = 3;
    localparam int POLL_MSB  = 7;
    localparam int START_LSB = 8;
    localparam int START_MSB = 23;
    // Word 3 fields
    localparam int DONE_LSB = 0;
    localparam int DONE_MSB = 14;
    localparam int NAK_LSB  = 19;
    localparam int NAK_MSB  = 22;
    localparam int CERR_LSB = 23;
    localparam int CERR_MSB = 24;
    localparam int DT_BIT   = 25;
    localparam int HALT_BIT = 30;
    // Word 4 fields
    localparam int NEXT_LSB = 0;
    localparam int NEXT_MSB = 4;
    localparam int JUMP_BIT = 5;
    localparam int USA_LSB  = 8;
    localparam int USA_MSB  = 15;

    localparam logic [1:0] KIND_INTERRUPT = 2'h3;

    // Register space
    localparam int REG_SPACE_BIT = 9;
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_MASK   = 3'h2;
    localparam logic [2:0] REG_CURSOR = 3'h3;
    localparam logic [2:0] REG_BUFCNV = 3'h4;
    localparam int EV_W     = 3;
    localparam int EV_DONE  = 0;
    localparam int EV_FATAL = 1;
    localparam int EV_SCAN  = 2;

    localparam logic [31:0] CPU_RAM_BASE = 32'h0000_0400;
    localparam int RAM_SHIFT = 3;

    typedef enum logic [1:0] {
        UTD_IDLE  = 2'b00,
        UTD_CHECK = 2'b01,
        UTD_ISSUE = 2'b11,
        UTD_WBACK = 2'b10
    } utd_state_t;

    typedef struct packed {
        logic [6:0]  hubAddr;
        logic [6:0]  hubPort;
        logic [1:0]  speedEndpoint;
        logic        split;
        logic [1:0]  endpointKind;
        logic [1:0]  token;
        logic [6:0]  functionAddr;
        logic [3:0]  endpointNumber;
        logic        dataToggle;
        logic [10:0] length;
        logic [15:0] payloadRamStart;
    } utd_txn_t;

    typedef struct packed {
        logic [10:0] bytes;
        logic        fatal;
    } utd_result_t;

    function automatic logic [15:0] utd_cpu_to_ram(input logic [31:0] cpuAddr);
        logic [31:0] diff;
        diff = (cpuAddr - CPU_RAM_BASE) >> RAM_SHIFT;
        return diff[15:0];
    endfunction
endpackage

/* logic/utd_transfer_descriptor_decode.sv */
`timescale 1ns/1ps
// Overview of operation
// - Multiplier sets packets issued per execution
// - Each packet limited to max packet bytes
// - Total payload from 15-bit bytes field
// - Clear active on completion or fatal error
// - Mask selects rate up to one ms
// - Poll bits select two to 32 ms
// - Decode hub, port, speed, split, token, addresses
// - Word 3 status, toggle, counts; word 4 branch
// - CPU address minus 400h, divided by 8
// - Split bit chooses split or plain transaction
// - Branch bit jumps to next descriptor index, only after an active, due descriptor
module utd_transfer_descriptor_decode (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic [9:0]            regAddr,
    input  wire logic [31:0]           regWrData,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic [31:0]                regRdData,
    output logic                       txnReq,
    output utd_pkg::utd_txn_t          txn,
    input  wire logic                  txnAck,
    input  wire utd_pkg::utd_result_t  txnResult,
    output logic                       irq
);
    logic [31:0] descRam [utd_pkg::SLOTS*8];

    utd_pkg::utd_state_t state_r, state_nxt;
    logic [4:0]  slot_r, slot_nxt, scanCnt_r, scanCnt_nxt;
    logic [1:0]  pktLeft_r, pktLeft_nxt;
    logic [14:0] done_r, done_nxt;
    logic        toggle_r, toggle_nxt, endExec_r, endExec_nxt, fatal_r, fatal_nxt;
    utd_pkg::utd_txn_t txn_r, txn_nxt;
    logic [utd_pkg::DIV_W-1:0] div_r, div_nxt;
    logic [2:0]  uframe_r, uframe_nxt;
    logic [4:0]  frame_r, frame_nxt;
    logic [utd_pkg::EV_W-1:0] status_r, status_nxt, mask_r, mask_nxt, events;
    logic        run_r, run_nxt;
    logic [15:0] bufConv_r, bufConv_nxt;
    logic [31:0] rdData_r, rdData_nxt;

    logic [31:0] w0, w1, w2, w3, w4;
    logic        tick, isReg, due, lastScan;
    logic [4:0]  pollBits, smear, branchSlot;
    logic [14:0] total, newDone, remaining;
    logic [10:0] maxPkt;

    assign w0 = descRam[{slot_r, utd_pkg::DW0}];
    assign w1 = descRam[{slot_r, utd_pkg::DW1}];
    assign w2 = descRam[{slot_r, utd_pkg::DW2}];
    assign w3 = descRam[{slot_r, utd_pkg::DW3}];
    assign w4 = descRam[{slot_r, utd_pkg::DW4}];
    assign tick = (div_r == utd_pkg::DIV_W'(utd_pkg::UFRAME_CYCLES - 1));
    assign isReg = regAddr[utd_pkg::REG_SPACE_BIT];
    assign total = w0[utd_pkg::BTM_MSB:utd_pkg::BTM_LSB];
    assign maxPkt = w0[utd_pkg::MPS_MSB:utd_pkg::MPS_LSB];
    assign newDone = done_r + 15'(txnResult.bytes);
    assign remaining = total - done_r;
    assign lastScan = (scanCnt_r == 5'(utd_pkg::SLOTS - 1));
    assign branchSlot = w4[utd_pkg::JUMP_BIT] ? w4[utd_pkg::NEXT_MSB:utd_pkg::NEXT_LSB]
                                              : slot_r + 5'h1;
    assign pollBits = w2[utd_pkg::POLL_MSB:utd_pkg::POLL_LSB];

    // Smearing the poll bits gives the frame-number bits that must be zero
    always_comb begin
        smear = pollBits;
        smear = smear | (smear >> 1);
        smear = smear | (smear >> 2);
        smear = smear | (smear >> 4);
        due = 1'b1;
        if (w1[utd_pkg::KIND_MSB:utd_pkg::KIND_LSB] == utd_pkg::KIND_INTERRUPT) begin
            due = w4[utd_pkg::USA_LSB + 32'(uframe_r)] && ((frame_r & smear) == 5'h0);
        end
    end

    // Packet length never exceeds max packet size or what is left
    function automatic utd_pkg::utd_txn_t build(input logic [14:0] doneBytes,
                                               input logic toggle);
        utd_pkg::utd_txn_t t;
        logic [14:0] left;
        left = total - doneBytes;
        t.hubAddr         = w1[utd_pkg::HUB_MSB:utd_pkg::HUB_LSB];
        t.hubPort         = w1[utd_pkg::PORT_MSB:utd_pkg::PORT_LSB];
        t.speedEndpoint   = w1[utd_pkg::SE_MSB:utd_pkg::SE_LSB];
        t.split           = w1[utd_pkg::SPLIT_BIT];
        t.endpointKind    = w1[utd_pkg::KIND_MSB:utd_pkg::KIND_LSB];
        t.token           = w1[utd_pkg::TOK_MSB:utd_pkg::TOK_LSB];
        t.functionAddr    = w1[utd_pkg::FADR_MSB:utd_pkg::FADR_LSB];
        t.endpointNumber  = {w1[utd_pkg::EPH_MSB:utd_pkg::EPH_LSB], w0[utd_pkg::EP0_BIT]};
        t.dataToggle      = toggle;
        t.length          = (left < 15'(maxPkt)) ? left[10:0] : maxPkt;
        t.payloadRamStart = w2[utd_pkg::START_MSB:utd_pkg::START_LSB];
        return t;
    endfunction

    always_comb begin
        state_nxt   = state_r;
        slot_nxt    = slot_r;
        scanCnt_nxt = scanCnt_r;
        pktLeft_nxt = pktLeft_r;
        done_nxt    = done_r;
        toggle_nxt  = toggle_r;
        endExec_nxt = endExec_r;
        fatal_nxt   = fatal_r;
        txn_nxt     = txn_r;
        events      = '0;
        case (state_r)
            utd_pkg::UTD_IDLE: begin
                if (tick && run_r) begin
                    state_nxt   = utd_pkg::UTD_CHECK;
                    slot_nxt    = 5'h0;
                    scanCnt_nxt = 5'h0;
                end
            end
            utd_pkg::UTD_CHECK: begin
                if (w0[utd_pkg::ACT_BIT] && due) begin
                    state_nxt   = utd_pkg::UTD_ISSUE;
                    pktLeft_nxt = w0[utd_pkg::MULT_MSB:utd_pkg::MULT_LSB];
                    done_nxt    = w3[utd_pkg::DONE_MSB:utd_pkg::DONE_LSB];
                    toggle_nxt  = w3[utd_pkg::DT_BIT];
                    endExec_nxt = 1'b0;
                    fatal_nxt   = 1'b0;
                    txn_nxt     = build(w3[utd_pkg::DONE_MSB:utd_pkg::DONE_LSB],
                                        w3[utd_pkg::DT_BIT]);
                    if (w0[utd_pkg::MULT_MSB:utd_pkg::MULT_LSB] == 2'h0) begin
                        state_nxt = utd_pkg::UTD_WBACK;
                    end
                end else begin
                    slot_nxt    = slot_r + 5'h1;
                    scanCnt_nxt = scanCnt_r + 5'h1;
                    if (lastScan) begin
                        state_nxt = utd_pkg::UTD_IDLE;
                        events[utd_pkg::EV_SCAN] = 1'b1;
                    end
                end
            end
            utd_pkg::UTD_ISSUE: begin
                if (txnAck) begin
                    pktLeft_nxt = pktLeft_r - 2'h1;
                    if (txnResult.fatal) begin
                        fatal_nxt   = 1'b1;
                        endExec_nxt = 1'b1;
                        state_nxt   = utd_pkg::UTD_WBACK;
                    end else begin
                        done_nxt   = newDone;
                        toggle_nxt = ~toggle_r;
                        if (newDone >= total || txnResult.bytes < txn_r.length) begin
                            endExec_nxt = 1'b1;
                            state_nxt   = utd_pkg::UTD_WBACK;
                        end else if (pktLeft_r == 2'h1) begin
                            state_nxt = utd_pkg::UTD_WBACK;
                        end else begin
                            txn_nxt = build(newDone, ~toggle_r);
                        end
                    end
                end
            end
            utd_pkg::UTD_WBACK: begin
                events[utd_pkg::EV_DONE]  = endExec_r && !fatal_r;
                events[utd_pkg::EV_FATAL] = fatal_r;
                slot_nxt    = branchSlot;
                scanCnt_nxt = scanCnt_r + 5'h1;
                state_nxt   = utd_pkg::UTD_CHECK;
                if (lastScan) begin
                    state_nxt = utd_pkg::UTD_IDLE;
                    events[utd_pkg::EV_SCAN] = 1'b1;
                end
            end
            default: state_nxt = utd_pkg::UTD_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= utd_pkg::UTD_IDLE;
            slot_r    <= 5'h0;
            scanCnt_r <= 5'h0;
            pktLeft_r <= 2'h0;
            done_r    <= 15'h0000;
            toggle_r  <= 1'b0;
            endExec_r <= 1'b0;
            fatal_r   <= 1'b0;
            txn_r     <= '0;
        end else begin
            state_r   <= state_nxt;
            slot_r    <= slot_nxt;
            scanCnt_r <= scanCnt_nxt;
            pktLeft_r <= pktLeft_nxt;
            done_r    <= done_nxt;
            toggle_r  <= toggle_nxt;
            endExec_r <= endExec_nxt;
            fatal_r   <= fatal_nxt;
            txn_r     <= txn_nxt;
        end
    end

    // Engine write-back first so a same-cycle software write wins
    always_ff @(posedge clk) begin
        if (state_r == utd_pkg::UTD_WBACK) begin
            descRam[{slot_r, utd_pkg::DW0}] <= {w0[31:1], w0[utd_pkg::ACT_BIT] & ~endExec_r};
            descRam[{slot_r, utd_pkg::DW3}] <= {w3[31], w3[utd_pkg::HALT_BIT] | fatal_r,
                                                w3[29:26], toggle_r, w3[24:15], done_r};
        end
        if (regWr && !isReg) begin
            descRam[regAddr[utd_pkg::RAM_AW-1:0]] <= regWrData;
        end
    end

    // Timebase, registers and interrupt
    always_comb begin
        div_nxt     = tick ? '0 : div_r + utd_pkg::DIV_W'(1);
        uframe_nxt  = tick ? uframe_r + 3'h1 : uframe_r;
        frame_nxt   = (tick && uframe_r == 3'h7) ? frame_r + 5'h1 : frame_r;
        run_nxt     = run_r;
        mask_nxt    = mask_r;
        bufConv_nxt = bufConv_r;
        status_nxt  = status_r;
        rdData_nxt  = 32'h0000_0000;
        if (regWr && isReg) begin
            case (regAddr[2:0])
                utd_pkg::REG_CTRL:   run_nxt = regWrData[0];
                utd_pkg::REG_STATUS: status_nxt = status_r & ~regWrData[utd_pkg::EV_W-1:0];
                utd_pkg::REG_MASK:   mask_nxt = regWrData[utd_pkg::EV_W-1:0];
                utd_pkg::REG_BUFCNV: bufConv_nxt = utd_pkg::utd_cpu_to_ram(regWrData);
                default: ;
            endcase
        end
        status_nxt = status_nxt | events;
        if (regRd) begin
            if (!isReg) begin
                rdData_nxt = descRam[regAddr[utd_pkg::RAM_AW-1:0]];
            end else begin
                case (regAddr[2:0])
                    utd_pkg::REG_CTRL:   rdData_nxt = {31'h0, run_r};
                    utd_pkg::REG_STATUS: rdData_nxt = {29'h0, status_r};
                    utd_pkg::REG_MASK:   rdData_nxt = {29'h0, mask_r};
                    utd_pkg::REG_CURSOR: rdData_nxt = {9'h000, state_r, uframe_r, frame_r,
                                                       3'h0, scanCnt_r, slot_r};
                    utd_pkg::REG_BUFCNV: rdData_nxt = {16'h0, bufConv_r};
                    default:             rdData_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r     <= '0;
            uframe_r  <= 3'h0;
            frame_r   <= 5'h0;
            run_r     <= 1'b0;
            mask_r    <= '0;
            status_r  <= '0;
            bufConv_r <= 16'h0000;
            rdData_r  <= 32'h0000_0000;
        end else begin
            div_r     <= div_nxt;
            uframe_r  <= uframe_nxt;
            frame_r   <= frame_nxt;
            run_r     <= run_nxt;
            mask_r    <= mask_nxt;
            status_r  <= status_nxt;
            bufConv_r <= bufConv_nxt;
            rdData_r  <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign txnReq    = (state_r == utd_pkg::UTD_ISSUE);
    assign txn       = txn_r;
    assign irq       = |(status_r & mask_r);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_skip_inactive: assert property (state_r == utd_pkg::UTD_CHECK && !w0[0]
        |=> state_r != utd_pkg::UTD_ISSUE) else $error("inactive slot issued");
    a_len_limit: assert property (txnReq |-> txn.length <= maxPkt)
        else $error("packet longer than max size");
    a_len_total: assert property (txnReq |-> 15'(txn.length) <= remaining)
        else $error("packet beyond total bytes");
    a_mult_count: assert property (txnReq && txnAck && !txnResult.fatal && pktLeft_r == 2'h1
        |=> !txnReq) else $error("too many packets per execution");
    a_fatal_clear: assert property (txnReq && txnAck && txnResult.fatal
        |=> ##1 !descRam[{$past(slot_r, 2), utd_pkg::DW0}][0] || $past(regWr, 1))
        else $error("active bit kept after fatal");
    a_split_sel: assert property (txnReq |-> txn.split == w1[14])
        else $error("split select mismatch");
    a_branch_jump: assert property (state_r == utd_pkg::UTD_WBACK && w4[5] && !lastScan
        |=> slot_r == $past(w4[4:0])) else $error("branch not taken");
    a_hub_decode: assert property (txnReq |-> txn.hubAddr == w1[31:25] && txn.hubPort == w1[24:18])
        else $error("hub fields misdecoded");
    a_poll_rate: assert property (state_r == utd_pkg::UTD_CHECK && w1[13:12] == 2'h3
        && !w4[8 + 32'(uframe_r)] |=> state_r != utd_pkg::UTD_ISSUE)
        else $error("interrupt polled off schedule");
    a_irq_level: assert property (events[0] && mask_r[0] |=> irq)
        else $error("interrupt not raised");

    c_packet: cover property (txnReq && txnAck);
    c_multi: cover property (txnReq && txnAck ##1 txnReq);
    c_fatal: cover property (txnReq && txnAck && txnResult.fatal);
    c_scan_end: cover property (events[utd_pkg::EV_SCAN]);
endmodule

/* bench/utd_usb_partner.sv */
`timescale 1ns/1ps
// Far side: acks each packet ackDelay + 1 cycles after its request; one address can come back short
// by six bytes, another can fail, so both descriptor endings are reachable
module utd_usb_partner (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 txnReq,
    input  wire utd_pkg::utd_txn_t    txn,
    output logic                      txnAck,
    output utd_pkg::utd_result_t      txnResult,
    input  wire logic [3:0]           ackDelay,
    input  wire logic [6:0]           shortAddr,
    input  wire logic [6:0]           fatalAddr
);
    logic [3:0] waitCnt;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            waitCnt   <= 4'h0;
            txnAck    <= 1'b0;
            txnResult <= '0;
        end else begin
            txnAck    <= 1'b0;
            // Outside an ack the result lines toggle, never holding the last answer
            txnResult <= ~txnResult;
            if (txnReq && !txnAck && waitCnt == ackDelay) begin
                waitCnt         <= 4'h0;
                txnAck          <= 1'b1;
                txnResult.bytes <= (txn.functionAddr == shortAddr) ? txn.length - 11'h6
                                                                  : txn.length;
                txnResult.fatal <= (txn.functionAddr == fatalAddr);
            end else if (txnReq && !txnAck) begin
                waitCnt <= waitCnt + 4'h1;
            end else begin
                waitCnt <= 4'h0;
            end
        end
    end
endmodule

/* bench/test_usb_transfer_descriptor_decode.sv */
`timescale 1ns/1ps
module test_usb_transfer_descriptor_decode;
    localparam int UF = 1250;
    logic                 clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic [9:0]           regAddr = 10'h000;
    logic [31:0]          regWrData = 32'h0000_0000;
    logic                 regWr = 1'b0;
    logic                 regRd = 1'b0;
    logic [31:0]          regRdData;
    logic                 txnReq;
    utd_pkg::utd_txn_t    txn;
    logic                 txnAck;
    utd_pkg::utd_result_t txnResult;
    logic                 irq;
    logic [3:0]           ackDelay = 4'h5;
    logic [6:0]           shortAddr = 7'h7F;
    logic [6:0]           fatalAddr = 7'h7F;
    int                   mismatches = 0;
    int                   compares = 0;
    int                   pktCnt = 0;
    int                   base;
    utd_pkg::utd_txn_t    txnLog[$];
    utd_pkg::utd_txn_t    expTxn;
    logic [31:0]          rdv;
    logic [7:0]           maskTab[5] = '{8'hFF, 8'hAA, 8'h11, 8'h01, 8'h08};
    logic [4:0]           pollTab[5] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h01};
    int                   winTab[5] = '{2, 4, 8, 8, 16};
    int                   expTab[5] = '{2, 2, 2, 1, 1};

    always #50 clk = ~clk;

    utd_transfer_descriptor_decode dut_u (
        .clk       (clk),
        .reset_n   (reset_n),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regWr     (regWr),
        .regRd     (regRd),
        .regRdData (regRdData),
        .txnReq    (txnReq),
        .txn       (txn),
        .txnAck    (txnAck),
        .txnResult (txnResult),
        .irq       (irq)
    );

    utd_usb_partner partner_u (
        .clk       (clk),
        .reset_n   (reset_n),
        .txnReq    (txnReq),
        .txn       (txn),
        .txnAck    (txnAck),
        .txnResult (txnResult),
        .ackDelay  (ackDelay),
        .shortAddr (shortAddr),
        .fatalAddr (fatalAddr)
    );

    always @(posedge clk) begin
        if (txnReq && txnAck) begin
            pktCnt <= pktCnt + 1;
            txnLog.push_back(txn);
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask

    // Bounded wait: a stalled engine shows up as a mismatch, not a hang
    task automatic wait_pkts(input int target, input int limit);
        int n;
        n = 0;
        while (pktCnt < target && n < limit) begin
            @(posedge clk);
            n++;
        end
        chk(pktCnt >= target, 1);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [9:0] ram(input int slot, input int w);
        return {2'b00, slot[4:0], w[2:0]};
    endfunction

    function automatic logic [31:0] w0(input logic [1:0] mult, input logic [10:0] mps,
                                       input logic [14:0] btm, input logic ep0);
        return {ep0, mult, mps, btm, 3'b001};
    endfunction

    function automatic logic [31:0] w1(input logic [6:0] fa, input logic [1:0] kind,
                                       input logic split);
        return {7'h55, 7'h2A, 2'h2, 1'b0, split, kind, 2'h1, fa, 3'b101};
    endfunction

    task automatic report_and_stop;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (100_000) @(posedge clk);
        mismatches++;
        report_and_stop;
    end

    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        settle(1);
        chk({regRdData, txnReq, irq}, 0);
        rd(10'h203, rdv);
        chk(rdv, 32'h0000_0000);
        wr(10'h204, 32'h0000_0C00);
        rd(10'h204, rdv);
        chk(rdv[15:0], 16'h0100);
        wr(10'h205, 32'hFFFF_FFFF);
        rd(10'h205, rdv);
        chk(rdv, 0);
        for (int s = 0; s < 32; s++)
            for (int w = 0; w < 5; w++)
                wr(ram(s, w), 32'h0000_0000);
        wr(10'h200, 32'h0000_0001);
        rd(10'h200, rdv);
        chk(rdv, 32'h0000_0001);
        settle(UF + 50);
        chk(pktCnt, 0);
        wr(ram(0, 1), w1(7'h33, 2'h2, 1'b1));
        wr(ram(0, 2), 32'h0000_1200);
        wr(ram(0, 0), w0(2'h2, 11'h008, 15'h0014, 1'b1));
        wait_pkts(2, 2 * UF);
        expTxn = {7'h55, 7'h2A, 2'h2, 1'b1, 2'h2, 2'h1, 7'h33, 4'hB, 1'b0, 11'h008, 16'h0012};
        chk(txnLog[0], expTxn);
        chk(txnLog[1].length, 11'h008);
        chk(txnLog[1].dataToggle, 1'b1);
        wait_pkts(3, 2 * UF);
        chk(txnLog[2].length, 11'h004);
        settle(UF + 50);
        chk(pktCnt, 3);
        rd(ram(0, 0), rdv);
        chk(rdv, w0(2'h2, 11'h008, 15'h0014, 1'b1) & 32'hFFFF_FFFE);
        rd(ram(0, 3), rdv);
        chk(rdv & 32'h0200_7FFF, 32'h0200_0014);
        rd(10'h201, rdv);
        chk({rdv[1:0], irq}, 3'b010);
        wr(10'h202, 32'h0000_0001);
        settle(2);
        chk(irq, 1'b1);
        wr(10'h201, 32'h0000_0001);
        settle(2);
        chk(irq, 1'b0);
        // Arm with the engine stopped so the branch is in place before any visit
        wr(10'h200, 32'h0000_0000);
        ackDelay  <= 4'h1;
        shortAddr <= 7'h02;
        fatalAddr <= 7'h05;
        wr(ram(2, 1), w1(7'h02, 2'h2, 1'b0));
        wr(ram(2, 4), 32'h0000_0025);
        wr(ram(2, 0), w0(2'h1, 11'h010, 15'h0010, 1'b0));
        wr(ram(3, 1), w1(7'h03, 2'h2, 1'b0));
        wr(ram(3, 0), w0(2'h1, 11'h008, 15'h0008, 1'b0));
        wr(ram(5, 1), w1(7'h05, 2'h2, 1'b0));
        wr(ram(5, 0), w0(2'h1, 11'h008, 15'h0040, 1'b0));
        base = pktCnt;
        wr(10'h200, 32'h0000_0001);
        wait_pkts(base + 2, 2 * UF);
        chk(txnLog[base].functionAddr, 7'h02);
        chk(txnLog[base].split, 1'b0);
        chk(txnLog[base + 1].functionAddr, 7'h05);
        wr(10'h200, 32'h0000_0000);
        wr(ram(3, 0), 32'h0000_0000);
        rd(ram(2, 0), rdv);
        chk(rdv[0], 1'b0);
        rd(ram(5, 0), rdv);
        chk(rdv[0], 1'b0);
        rd(ram(5, 3), rdv);
        chk(rdv[30], 1'b1);
        rd(10'h201, rdv);
        chk(rdv[1], 1'b1);
        shortAddr <= 7'h7F;
        fatalAddr <= 7'h7F;
        wr(10'h200, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            wr(ram(4, 0), 32'h0000_0000);
            wr(ram(4, 1), w1(7'h04, 2'h3, 1'b0));
            wr(ram(4, 2), {24'h00_0000, pollTab[i], 3'b000});
            wr(ram(4, 3), 32'h0000_0000);
            wr(ram(4, 4), {16'h0000, maskTab[i], 8'h00});
            wr(ram(4, 0), w0(2'h1, 11'h008, 15'h7FF8, 1'b0));
            wait_pkts(pktCnt + 1, 17 * UF);
            base = pktCnt;
            settle(winTab[i] * UF - 20);
            chk(pktCnt - base + 1, expTab[i]);
        end
        report_and_stop;
    end
endmodule
